// >>> logic/gppm_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "gppm_params.svh"
module gppm_top #(
  parameter int NP = `GPPM_NUM_PORTS,
  parameter int PW = `GPPM_PORT_WIDTH
) (
  input  wire logic                 CLK_SYS,
  input  wire logic                 RST,
  input  wire logic [NP*PW-1:0]     PIN_IN,
  output logic      [NP*PW-1:0]     PIN_OUT,
  output logic      [NP*PW-1:0]     PIN_OE,
  output logic      [NP*PW-1:0]     PIN_IE,
  input  wire logic [NP*PW-1:0]     SW_OUT_WR_DATA,
  input  wire logic [NP-1:0]        SW_OUT_WR,
  input  wire logic [NP*PW-1:0]     DIR_OUT_EN,
  input  wire logic [NP*PW-1:0]     IN_BUF_EN,
  input  wire logic [NP*PW*3-1:0]   SEL_WR_DATA,
  input  wire logic [NP-1:0]        SEL_WR,
  input  wire logic [NP*PW-1:0]     IRQ_EN,
  input  wire logic [NP*PW*2-1:0]   IRQ_EDGE,
  input  wire logic [NP*PW-1:0]     IRQ_CLR,
  output logic      [NP*PW-1:0]     SW_OUT_VALUE,
  output logic      [NP*PW-1:0]     PIN_STATE,
  output logic      [NP*PW-1:0]     IRQ_PEND,
  output logic      [NP-1:0]        PORT_IRQ,
  input  wire logic [NP*PW-1:0]     FABRIC_OUT,
  output logic      [NP*PW-1:0]     FABRIC_IN,
  input  wire logic [3:0]           PWM_RAW_OUT,
  input  wire logic                 SERIAL_B_UART_TRANSMIT,
  output logic                      SERIAL_B_UART_RECEIVE,
  input  wire logic                 SERIAL_B_SCL_OUT,
  input  wire logic                 SERIAL_B_SDA_OUT,
  output logic                      SERIAL_B_SCL_IN,
  output logic                      SERIAL_B_SDA_IN,
  input  wire logic                 SERIAL_B_SPI_MOSI,
  output logic                      SERIAL_B_SPI_MISO,
  input  wire logic                 SERIAL_B_SPI_CLK,
  input  wire logic                 SERIAL_B_SPI_SEL0,
  input  wire logic                 SERIAL_A_UART_TRANSMIT,
  output logic                      SERIAL_A_UART_RECEIVE,
  input  wire logic                 SERIAL_A_SCL_OUT,
  input  wire logic                 SERIAL_A_SDA_OUT,
  output logic                      SERIAL_A_SCL_IN,
  output logic                      SERIAL_A_SDA_IN,
  input  wire logic                 SERIAL_A_SPI_MOSI,
  output logic                      SERIAL_A_SPI_MISO,
  input  wire logic                 SERIAL_A_SPI_CLK,
  input  wire logic [3:0]           SERIAL_A_SPI_SEL,
  input  wire logic                 DEBUG_DATA_OUT,
  input  wire logic                 DEBUG_DATA_OE,
  output logic                      DEBUG_DATA_IN,
  output logic                      DEBUG_CLK_IN,
  output logic                      EXT_CLK_IN,
  output logic                      WAKEUP_IN
);
  import gppm_pkg::*;

  localparam int NB = NP*PW;
  localparam int P0 = 0*PW;
  localparam int P1 = 1*PW;
  localparam int P2 = 2*PW;
  localparam int P3 = 3*PW;
  localparam int P4 = 4*PW;

  logic [NB-1:0]   sw_out_q;
  logic [NB*3-1:0] sel_q;
  logic [NB-1:0]   sync1_q;
  logic [NB-1:0]   sync2_q;
  logic [NB-1:0]   prev_q;
  logic [NB-1:0]   pend_q;
  logic            run_q;
  logic [2:0]      warm_q;
  logic [NB-1:0]   alt_out [1:4];
  logic [NB-1:0]   alt_oe  [1:4];
  logic [NB-1:0]   mux_out;
  logic [NB-1:0]   mux_oe;
  logic [NB-1:0]   pend_set;
  logic [3:0]      pwm_true;
  logic [3:0]      pwm_comp;

  assign pwm_true = PWM_RAW_OUT;
  assign pwm_comp = ~PWM_RAW_OUT;

  // fixed pin locations; unlisted pins carry nothing
  always_comb begin
    for (int a = 1; a <= 4; a++) begin
      alt_out[a] = '0;
      alt_oe[a]  = '0;
    end
    // port 3 pins 0 and 1
    alt_out[1][P3+0] = pwm_true[0];
    alt_oe[1][P3+0]  = 1'b1;
    alt_out[1][P3+1] = pwm_comp[0];
    alt_oe[1][P3+1]  = 1'b1;
    alt_out[2][P3+1] = SERIAL_B_UART_TRANSMIT;
    alt_oe[2][P3+1]  = 1'b1;
    // Open drain: drive only the low level
    alt_oe[3][P3+0]  = ~SERIAL_B_SCL_OUT;
    alt_oe[3][P3+1]  = ~SERIAL_B_SDA_OUT;
    alt_out[4][P3+0] = SERIAL_B_SPI_MOSI;
    alt_oe[4][P3+0]  = 1'b1;
    // port 3 pins 2 and 3
    alt_out[1][P3+2] = pwm_true[1];
    alt_oe[1][P3+2]  = 1'b1;
    alt_out[1][P3+3] = pwm_comp[1];
    alt_oe[1][P3+3]  = 1'b1;
    alt_out[3][P3+2] = DEBUG_DATA_OUT;
    alt_oe[3][P3+2]  = DEBUG_DATA_OE;
    alt_out[4][P3+2] = SERIAL_B_SPI_CLK;
    alt_oe[4][P3+2]  = 1'b1;
    alt_out[4][P3+3] = SERIAL_B_SPI_SEL0;
    alt_oe[4][P3+3]  = 1'b1;
    alt_out[2][P4+1] = SERIAL_A_UART_TRANSMIT;
    alt_oe[2][P4+1]  = 1'b1;
    alt_oe[3][P4+0]  = ~SERIAL_A_SCL_OUT;
    alt_oe[3][P4+1]  = ~SERIAL_A_SDA_OUT;
    alt_out[4][P4+0] = SERIAL_A_SPI_MOSI;
    alt_oe[4][P4+0]  = 1'b1;
    alt_out[4][P4+2] = SERIAL_A_SPI_CLK;
    alt_oe[4][P4+2]  = 1'b1;
    alt_out[4][P4+3] = SERIAL_A_SPI_SEL[0];
    alt_oe[4][P4+3]  = 1'b1;
    for (int s = 0; s < 3; s++) begin
      alt_out[4][P0+s] = SERIAL_A_SPI_SEL[s+1];
      alt_oe[4][P0+s]  = 1'b1;
    end
    alt_out[4][P0+6] = SERIAL_B_SPI_CLK;
    alt_oe[4][P0+6]  = 1'b1;
    alt_out[4][P0+7] = SERIAL_B_SPI_SEL0;
    alt_oe[4][P0+7]  = 1'b1;
    alt_out[1][P2+4] = pwm_true[0];
    alt_out[1][P2+5] = pwm_comp[0];
    alt_out[1][P2+6] = pwm_true[1];
    alt_out[1][P2+7] = pwm_comp[1];
    // port 1 pwm units 2 and 3
    alt_out[1][P1+0] = pwm_true[2];
    alt_out[1][P1+1] = pwm_comp[2];
    alt_out[1][P1+2] = pwm_true[3];
    for (int k = 4; k < 8; k++) begin
      alt_oe[1][P2+k] = 1'b1;
    end
    for (int k = 0; k < 3; k++) begin
      alt_oe[1][P1+k] = 1'b1;
    end
  end

  // Peripheral inputs from synchronised pins, gated by selection
  wire [NB-1:0] s = sync2_q;
  function automatic logic is_sel(input logic [NB*3-1:0] v, input int b,
                                  input logic [2:0] code);
    return v[b*3 +: 3] == code;
  endfunction : is_sel
  // receive side only from fixed pins
  assign SERIAL_B_UART_RECEIVE = is_sel(sel_q, P3+0, `GPPM_SEL_ALT2) ?
                                 s[P3+0] : 1'b1;
  assign SERIAL_B_SCL_IN = is_sel(sel_q, P3+0, `GPPM_SEL_ALT3) ?
                           s[P3+0] : 1'b1;
  assign SERIAL_B_SDA_IN = is_sel(sel_q, P3+1, `GPPM_SEL_ALT3) ?
                           s[P3+1] : 1'b1;
  assign SERIAL_B_SPI_MISO = is_sel(sel_q, P3+1, `GPPM_SEL_ALT4) ?
                             s[P3+1] : 1'b0;
  assign SERIAL_A_UART_RECEIVE = is_sel(sel_q, P4+0, `GPPM_SEL_ALT2) ?
                                 s[P4+0] : 1'b1;
  assign SERIAL_A_SCL_IN = is_sel(sel_q, P4+0, `GPPM_SEL_ALT3) ?
                           s[P4+0] : 1'b1;
  assign SERIAL_A_SDA_IN = is_sel(sel_q, P4+1, `GPPM_SEL_ALT3) ?
                           s[P4+1] : 1'b1;
  assign SERIAL_A_SPI_MISO = is_sel(sel_q, P4+1, `GPPM_SEL_ALT4) ?
                             s[P4+1] : 1'b0;
  assign DEBUG_DATA_IN = is_sel(sel_q, P3+2, `GPPM_SEL_ALT3) ?
                         s[P3+2] : 1'b0;
  assign DEBUG_CLK_IN = is_sel(sel_q, P3+3, `GPPM_SEL_ALT3) ?
                        s[P3+3] : 1'b0;
  assign EXT_CLK_IN = is_sel(sel_q, P0+6, `GPPM_SEL_ALT1) ? s[P0+6] : 1'b0;
  assign WAKEUP_IN = is_sel(sel_q, P0+7, `GPPM_SEL_ALT3) ? s[P0+7] : 1'b0;

  // every pin reaches the fabric regardless of selection
  assign FABRIC_IN = s;

  genvar g;
  generate
    for (g = 0; g < NB; g++) begin : g_pin
      wire [2:0] sel_w = sel_q[g*3 +: 3];
      wire [1:0] edge_w = IRQ_EDGE[g*2 +: 2];
      wire rise_w = s[g] & ~prev_q[g];
      wire fall_w = ~s[g] & prev_q[g];
      logic ev_w;
      always_comb begin
        unique case (sel_w)
          `GPPM_SEL_SW: begin
            mux_out[g] = sw_out_q[g];
            mux_oe[g]  = DIR_OUT_EN[g];
          end
          `GPPM_SEL_ALT1, `GPPM_SEL_ALT2,
          `GPPM_SEL_ALT3, `GPPM_SEL_ALT4: begin
            mux_out[g] = alt_out[sel_w][g];
            mux_oe[g]  = alt_oe[sel_w][g];
          end
          `GPPM_SEL_FABRIC: begin
            mux_out[g] = FABRIC_OUT[g];
            mux_oe[g]  = DIR_OUT_EN[g];
          end
          default: begin
            mux_out[g] = 1'b0;
            mux_oe[g]  = 1'b0;
          end
        endcase
      end
      always_comb begin
        unique case (gppm_edge_t'(edge_w))
          GPPM_EDGE_RISE: ev_w = rise_w;
          GPPM_EDGE_FALL: ev_w = fall_w;
          GPPM_EDGE_BOTH: ev_w = rise_w | fall_w;
          GPPM_EDGE_HIGH: ev_w = s[g];
        endcase
      end
      // enable gates the event
      // Held off until the edge history holds real levels: pulled-up pins
      // would otherwise show a false rise right after reset
      assign pend_set[g] = IRQ_EN[g] & ev_w & warm_q[2];
    end
  endgenerate

  // buffers disabled until the first cycle after reset
  assign PIN_OUT = run_q ? mux_out : '0;
  assign PIN_OE  = run_q ? mux_oe : '0;
  assign PIN_IE  = run_q ? IN_BUF_EN : '0;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end else begin
      sync1_q <= PIN_IN;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      run_q  <= 1'b0;
      warm_q <= '0;
    end else begin
      run_q  <= 1'b1;
      warm_q <= {warm_q[1:0], 1'b1};
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sw_out_q <= '0;
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (SW_OUT_WR[p]) begin
          sw_out_q[p*PW +: PW] <= SW_OUT_WR_DATA[p*PW +: PW];
        end
      end
    end
  end

  // debug selection at reset
  // Widened first so the shifts keep their bits
  localparam logic [NB*3-1:0] SEL_ALT3_W = (NB*3)'(`GPPM_SEL_ALT3);
  localparam logic [NB*3-1:0] SEL_RST =
    (SEL_ALT3_W << ((P3+`GPPM_DBG_PIN_CLK)*3)) |
    (SEL_ALT3_W << ((P3+`GPPM_DBG_PIN_DATA)*3));
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sel_q <= SEL_RST;
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (SEL_WR[p]) begin
          sel_q[p*PW*3 +: PW*3] <= SEL_WR_DATA[p*PW*3 +: PW*3];
        end
      end
    end
  end

  // Set wins over clear so no edge is lost
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~IRQ_CLR) | pend_set;
    end
  end

  assign PIN_STATE    = sync2_q;
  assign SW_OUT_VALUE = sw_out_q;
  assign IRQ_PEND     = pend_q;

  generate
    for (g = 0; g < NP; g++) begin : g_port
      assign PORT_IRQ[g] = |(pend_q[g*PW +: PW] & IRQ_EN[g*PW +: PW]);
    end
  endgenerate

  sync_lat_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    PIN_STATE == $past(PIN_IN, 2) || $past(RST, 2) || $past(RST))
    else $error("pin state not two cycles behind pin");
  irq_gate_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (~IRQ_EN & ~$past(pend_q) & ~$past(IRQ_CLR) & ~pend_q) ==
    (~IRQ_EN & ~$past(pend_q) & ~$past(IRQ_CLR)) || $changed(IRQ_EN))
    else $error("disabled pin raised event");
  port_irq_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    PORT_IRQ[3] == |(IRQ_PEND[P3 +: PW] & IRQ_EN[P3 +: PW]))
    else $error("port request mismatch");
  reset_off_a: assert property (@(posedge CLK_SYS)
    $past(RST) |-> PIN_OE == '0 && PIN_IE == '0)
    else $error("pin enabled during reset");
  pwm_pol_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    run_q && is_sel(sel_q, P3+0, `GPPM_SEL_ALT1) &&
    is_sel(sel_q, P3+1, `GPPM_SEL_ALT1) |->
    PIN_OUT[P3+1] == ~PIN_OUT[P3+0])
    else $error("pwm pair not complementary");
  dbg_rst_a: assert property (@(posedge CLK_SYS)
    $fell(RST) |-> is_sel(sel_q, P3+2, `GPPM_SEL_ALT3) &&
    is_sel(sel_q, P3+3, `GPPM_SEL_ALT3))
    else $error("debug pins not selected after reset");
  sw_out_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    SW_OUT_WR[0] |=> SW_OUT_VALUE[P0 +: PW] == $past(SW_OUT_WR_DATA[P0 +: PW]))
    else $error("output register not written");
  sw_mux_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    run_q && is_sel(sel_q, P0+3, `GPPM_SEL_SW) |->
    PIN_OUT[P0+3] == SW_OUT_VALUE[P0+3])
    else $error("software value not on pin");
endmodule : gppm_top
`default_nettype wire

// >>> logic/gppm_params.svh
`ifndef GPPM_PARAMS_SVH
`define GPPM_PARAMS_SVH
`define GPPM_PORT_WIDTH   8
`define GPPM_NUM_PORTS    5
`define GPPM_SEL_WIDTH    3
`define GPPM_SEL_SW       3'h0
`define GPPM_SEL_ALT1     3'h1
`define GPPM_SEL_ALT2     3'h2
`define GPPM_SEL_ALT3     3'h3
`define GPPM_SEL_ALT4     3'h4
`define GPPM_SEL_FABRIC   3'h5
`define GPPM_DBG_PORT     3
`define GPPM_DBG_PIN_DATA 2
`define GPPM_DBG_PIN_CLK  3
`endif

// >>> logic/gppm_pkg.sv
`include "gppm_params.svh"
package gppm_pkg;
  typedef logic [`GPPM_PORT_WIDTH-1:0] gppm_port_t;
  typedef logic [`GPPM_SEL_WIDTH-1:0]  gppm_sel_t;
  typedef enum logic [1:0] {
    GPPM_EDGE_RISE = 2'b00,
    GPPM_EDGE_FALL = 2'b01,
    GPPM_EDGE_BOTH = 2'b10,
    GPPM_EDGE_HIGH = 2'b11
  } gppm_edge_t;
endpackage : gppm_pkg

// >>> sim/gppm_board.sv
`timescale 1ns/10ps
`default_nettype none
module gppm_board (
  input  wire logic [39:0] pin_out,
  input  wire logic [39:0] pin_oe,
  input  wire logic [39:0] ext_val,
  input  wire logic [39:0] ext_en,
  input  wire logic        chip_reset_n,
  output logic      [39:0] pin_in,
  output logic             rst
);
  assign rst = ~chip_reset_n;
  // Released pins float up through the board pull-ups
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                | (~pin_oe & ~ext_en);
endmodule : gppm_board
`default_nettype wire

// >>> sim/gppm_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "gppm_params.svh"
module gppm_tb_top;
  logic         clk, chip_reset_n, rst, v, w, a_miso, dbg_d, dbg_c;
  logic         ext_c, wake;
  logic [39:0]  pin_in, pin_out, pin_oe, pin_ie, ext_val, ext_en;
  logic [39:0]  sw_data, dir_en, irq_en, irq_clr, fab_out, mask;
  logic [39:0]  sw_val, pin_state, irq_pend, fab_in, exp_v;
  logic [119:0] sel_data;
  logic [4:0]   sw_wr, sel_wr, port_irq;
  int           errors, compares, n;

  assign w = ~v;

  gppm_board board (
    .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
    .ext_en(ext_en), .chip_reset_n(chip_reset_n), .pin_in(pin_in),
    .rst(rst)
  );

  gppm_top dut (
    .CLK_SYS(clk), .RST(rst), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_OE(pin_oe), .PIN_IE(pin_ie), .SW_OUT_WR_DATA(sw_data),
    .SW_OUT_WR(sw_wr), .DIR_OUT_EN(dir_en),
    .IN_BUF_EN(40'hFF_FFFF_FFFF), .SEL_WR_DATA(sel_data),
    .SEL_WR(sel_wr), .IRQ_EN(irq_en), .IRQ_EDGE(80'h0),
    .IRQ_CLR(irq_clr), .SW_OUT_VALUE(sw_val), .PIN_STATE(pin_state),
    .IRQ_PEND(irq_pend), .PORT_IRQ(port_irq), .FABRIC_OUT(fab_out),
    .FABRIC_IN(fab_in), .PWM_RAW_OUT({v, w, v, w}),
    .SERIAL_B_UART_TRANSMIT(v), .SERIAL_B_UART_RECEIVE(),
    .SERIAL_B_SCL_OUT(v), .SERIAL_B_SDA_OUT(w), .SERIAL_B_SCL_IN(),
    .SERIAL_B_SDA_IN(), .SERIAL_B_SPI_MOSI(v), .SERIAL_B_SPI_MISO(),
    .SERIAL_B_SPI_CLK(v), .SERIAL_B_SPI_SEL0(w),
    .SERIAL_A_UART_TRANSMIT(w), .SERIAL_A_UART_RECEIVE(),
    .SERIAL_A_SCL_OUT(v), .SERIAL_A_SDA_OUT(w), .SERIAL_A_SCL_IN(),
    .SERIAL_A_SDA_IN(), .SERIAL_A_SPI_MOSI(v), .SERIAL_A_SPI_MISO(a_miso),
    .SERIAL_A_SPI_CLK(w), .SERIAL_A_SPI_SEL({w, v, w, v}),
    .DEBUG_DATA_OUT(v), .DEBUG_DATA_OE(1'b0), .DEBUG_DATA_IN(dbg_d),
    .DEBUG_CLK_IN(dbg_c), .EXT_CLK_IN(ext_c), .WAKEUP_IN(wake)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wsel(input int p, input logic [23:0] s);
    sel_data[p*24+:24] = s;
    sel_wr[p] = 1'b1;
    tick(1);
    sel_wr = '0;
    tick(1);
  endtask : wsel

  task automatic end_of_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    errors = 0;
    compares = 0;
    chip_reset_n = 1'b0;
    v = 1'b0;
    ext_val = '0;
    ext_en = '1;
    {sw_data, dir_en, irq_en, irq_clr, fab_out} = '0;
    {sel_data, sw_wr, sel_wr} = '0;
    mask = 40'h0D_0FF0_0707;
    tick(10);
    chk(pin_oe | pin_ie, '0);
    tick(10);
    chip_reset_n = 1'b1;
    tick(2);
    chk(pin_ie, 40'hFF_FFFF_FFFF);
    for (n = 0; n < 2; n++) begin
      ext_val[27:26] = n ? 2'b01 : 2'b10;
      tick(4);
      chk({dbg_c, dbg_d}, ext_val[27:26]);
    end
    dir_en[7:0] = 8'hFF;
    sw_data[15:0] = 16'hAAC3;
    sw_wr[0] = 1'b1;
    tick(1);
    sw_wr = '0;
    chk({sw_val[15:0], pin_out[7:0], pin_oe[7:0]}, 32'h00C3_C3FF);
    fab_out[7:0] = 8'h5A;
    wsel(0, {8{`GPPM_SEL_FABRIC}});
    chk(pin_out[7:0], 8'h5A);
    ext_val[15] = 1'b1;
    tick(1);
    chk(pin_state[15], 1'b0);
    tick(1);
    chk({pin_state[15], fab_in[15]}, 2'b11);
    tick(6);
    chk({irq_pend[15], port_irq}, '0);
    irq_en[15] = 1'b1;
    ext_val[15] = 1'b0;
    tick(4);
    ext_val[15] = 1'b1;
    n = 0;
    while (port_irq[1] !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    chk({n[3:0], irq_pend, port_irq}, {4'h3, 40'h00_0000_8000, 5'h02});
    irq_clr[15] = 1'b1;
    tick(1);
    irq_clr = '0;
    chk({irq_pend[15], port_irq}, '0);
    wsel(2, {{4{`GPPM_SEL_ALT1}}, 12'h000});
    wsel(1, {15'h0000, {3{`GPPM_SEL_ALT1}}});
    wsel(3, {12'h000, `GPPM_SEL_ALT4, `GPPM_SEL_ALT4, {2{`GPPM_SEL_ALT1}}});
    wsel(0, {15'h0000, {3{`GPPM_SEL_ALT4}}});
    wsel(4, {12'h000, {4{`GPPM_SEL_ALT4}}});
    for (n = 0; n < 2; n++) begin
      v = n[0];
      ext_val[33] = ~v;
      tick(4);
      exp_v = {4'h0, v, w, 1'b0, v, 4'h0, w, v, v, w, w, v, v, w, 4'h0,
               5'h00, v, v, w, 5'h00, w, v, w};
      chk({a_miso, pin_out & mask}, {w, exp_v});
      chk(pin_oe & mask, mask);
    end
    wsel(0, {`GPPM_SEL_ALT3, `GPPM_SEL_ALT1, 18'h0_0000});
    ext_val[7:6] = 2'b10;
    tick(4);
    chk({wake, ext_c}, 2'b10);
    end_of_test();
  end
endmodule : gppm_tb_top
`default_nettype wire
